// >>> rtl/cro_pkg.sv
package cro_pkg;

    // -------------------------------------------------------------
    // Clock and time base
    // -------------------------------------------------------------
    localparam int CRO_CLK_HZ = 50_000_000;
    localparam int CRO_TICK_HZ = 1_000;
    localparam int CRO_TICK_CYCLES = CRO_CLK_HZ / CRO_TICK_HZ;
    localparam int CRO_TICK_W = 10;

    // Role shutdown delays, blink half period and wake pulse length, in ms ticks
    localparam int CRO_DLY_POS1_MS = 800;
    localparam int CRO_DLY_POS2_MS = 600;
    localparam int CRO_DLY_POS3_MS = 400;
    localparam int CRO_BLINK_HALF_MS = 500;
    localparam int CRO_WAKE_PULSE_MS = 10;

    // -------------------------------------------------------------
    // Management bus command and role encodings
    // -------------------------------------------------------------
    localparam logic [7:0] CRO_CMD_ROLE = 8'hd0;
    localparam logic [7:0] CRO_ROLE_STD = 8'h00;
    localparam logic [7:0] CRO_ROLE_ACTIVE = 8'h01;
    localparam logic [7:0] CRO_ROLE_POS1 = 8'h02;
    localparam logic [7:0] CRO_ROLE_POS2 = 8'h03;
    localparam logic [7:0] CRO_ROLE_POS3 = 8'h04;
    localparam logic [7:0] CRO_ROLE_RESET = 8'h00;
    localparam logic [7:0] CRO_PEC_POLY = 8'h07;
    localparam logic [7:0] CRO_PEC_INIT = 8'h00;
    localparam logic [7:0] CRO_READ_IDLE = 8'h00;

    typedef enum logic [1:0] {
        CRO_RUN = 2'b00,
        CRO_DELAY = 2'b01,
        CRO_STANDBY = 2'b11
    } cro_state_e;

    // One byte transaction handed over by the bus front end
    typedef struct packed {
        logic write;
        logic [6:0] addr;
        logic [7:0] cmd;
        logic [7:0] data;
        logic [7:0] pec;
    } cro_mb_req_s;

    typedef struct packed {
        logic ack;
        logic [7:0] data;
        logic [7:0] pec;
    } cro_mb_rsp_s;

    typedef struct packed {
        logic oc_warn;
        logic oc_fault;
        logic ov_fault;
        logic uv_smart;
        logic ot_fault;
        logic fan_fault;
        logic ac_loss;
    } cro_fault_s;

    typedef struct packed {
        logic temp_warn;
        logic power_warn;
        logic fan_slow;
    } cro_warn_s;

endpackage

// >>> rtl/cro_pec.sv
`timescale 1ns/1ps
// CRC-8 packet error code over NB bytes, first byte in the top bits
module cro_pec import cro_pkg::*; #(
    parameter int NB = 3
) (
    // Message
    input wire logic [8*NB-1:0] msg,
    // Code
    output logic [7:0] pec
);

    always_comb begin
        logic [7:0] c;
        c = CRO_PEC_INIT;
        for (int i = 8*NB-1; i >= 0; i--) begin
            if (c[7] ^ msg[i]) begin
                c = {c[6:0], 1'b0} ^ CRO_PEC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        pec = c;
    end

endmodule

// >>> rtl/cro_control.sv
`timescale 1ns/1ps
// Operation
// - Bus high, standby role, low load: standby
// - Shared standby bus low wakes standby
// - Role byte at command d0h, PEC checked
// - Role 00h default, on, blocks peer standby
// - Role 01h stays always on
// - Role 02h: off after 800 ms
// - Role 03h: off after 600 ms
// - Role 04h: off after 400 ms
// - Any fault returns role to 00h
// - Standby needs on, no redundancy, role 2-4
// - Standby keeps power good and fans
// - Standby hides faults; fault leaves standby
// - Standby LED blinks green, amber on warning
// - Standby wakes on per-position share threshold
// - Faults drive shared wake line low
// - Listed triggers drive the wake line
// - Extraction cutoff high forces output off
// - Output on only with both pins low
// - Presence output always low
// - On request off turns main output off
module cro_control import cro_pkg::*; #(
    parameter int TICK_CYCLES = CRO_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Pins from the system
    input wire logic on_request_n,
    input wire logic extraction_cutoff,
    input wire logic redundancy_select_n,
    // Wired shared standby bus
    input wire logic smart_on_bus_in,
    output logic smart_on_bus_out,
    output logic smart_on_bus_oe,
    // Wired shared wake fault line
    input wire logic shared_wake_fault_n_in,
    output logic shared_wake_fault_n_out,
    output logic shared_wake_fault_n_oe,
    // Load share comparators, one per standby position
    input wire logic [2:0] share_above_wake,
    // Internal protection sources
    input wire cro_fault_s faults,
    input wire cro_warn_s warnings,
    // Management bus transactions
    input wire logic mb_req_valid,
    input wire cro_mb_req_s mb_req,
    output logic mb_rsp_valid,
    output cro_mb_rsp_s mb_rsp,
    // Outputs
    output logic main_on,
    output logic power_good,
    output logic fans_run,
    output logic led_green,
    output logic led_amber,
    output logic present_n,
    output cro_fault_s fault_report,
    output logic [7:0] role
);

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
    localparam logic [CRO_TICK_W-1:0] DLY1 = CRO_TICK_W'(CRO_DLY_POS1_MS);
    localparam logic [CRO_TICK_W-1:0] DLY2 = CRO_TICK_W'(CRO_DLY_POS2_MS);
    localparam logic [CRO_TICK_W-1:0] DLY3 = CRO_TICK_W'(CRO_DLY_POS3_MS);
    localparam logic [CRO_TICK_W-1:0] BLINK = CRO_TICK_W'(CRO_BLINK_HALF_MS - 1);
    localparam logic [CRO_TICK_W-1:0] WPULSE = CRO_TICK_W'(CRO_WAKE_PULSE_MS);

    // -------------------------------------------------------------
    // Reset release and pin synchronisers
    // -------------------------------------------------------------
    logic rst_q1;
    logic rst_sync_n;
    logic [4:0] pin_q1;
    logic [4:0] pin_q2;
    logic on_req;
    logic kill;
    logic red_sel_n;
    logic bus_high;
    logic wake_n;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_q1 <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_sync_n <= rst_q1;
        end
    end

    // Pins idle at their pulled-up levels, so reset to ones
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_q1 <= 5'h1f;
            pin_q2 <= 5'h1f;
        end else begin
            pin_q1 <= {on_request_n, extraction_cutoff, redundancy_select_n,
                       smart_on_bus_in, shared_wake_fault_n_in};
            pin_q2 <= pin_q1;
        end
    end

    assign on_req = !pin_q2[4];
    assign kill = pin_q2[3];
    assign red_sel_n = pin_q2[2];
    assign bus_high = pin_q2[1];
    assign wake_n = pin_q2[0];

    // -------------------------------------------------------------
    // Millisecond tick
    // -------------------------------------------------------------
    logic [TW-1:0] tick_cnt;
    logic tick;

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == TICK_LAST);
            tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'b1;
        end
    end

    // -------------------------------------------------------------
    // Role register over the management bus
    // -------------------------------------------------------------
    logic any_fault;
    logic [7:0] pec_wr;
    logic [7:0] pec_rd;
    logic role_hit;
    logic wr_ok;
    logic std_written;

    assign any_fault = |faults;
    assign role_hit = mb_req.cmd == CRO_CMD_ROLE;

    cro_pec #(.NB(3)) u_pec_wr (
        .msg({mb_req.addr, 1'b0, mb_req.cmd, mb_req.data}),
        .pec(pec_wr)
    );

    cro_pec #(.NB(4)) u_pec_rd (
        .msg({mb_req.addr, 1'b0, mb_req.cmd, mb_req.addr, 1'b1, role}),
        .pec(pec_rd)
    );

    assign wr_ok = mb_req_valid && mb_req.write && role_hit && (pec_wr == mb_req.pec);
    assign std_written = wr_ok && (mb_req.data == CRO_ROLE_STD);

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            role <= CRO_ROLE_RESET;
        end else if (any_fault) begin
            role <= CRO_ROLE_RESET;
        end else if (wr_ok) begin
            role <= mb_req.data;
        end
    end

    // Byte read returns role with its PEC
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mb_rsp_valid <= 1'b0;
            mb_rsp <= '0;
        end else begin
            mb_rsp_valid <= mb_req_valid;
            mb_rsp.ack <= mb_req_valid && role_hit && (!mb_req.write || wr_ok);
            mb_rsp.data <= (mb_req_valid && role_hit && !mb_req.write) ? role : CRO_READ_IDLE;
            mb_rsp.pec <= (mb_req_valid && role_hit && !mb_req.write) ? pec_rd : CRO_READ_IDLE;
        end
    end

    // -------------------------------------------------------------
    // Standby decision
    // -------------------------------------------------------------
    cro_state_e state;
    logic standby_role;
    logic [1:0] pos;
    logic entry_ok;
    logic wake_req;
    logic [CRO_TICK_W-1:0] dly_cnt;
    logic [CRO_TICK_W-1:0] dly_target;

    always_comb begin
        standby_role = 1'b1;
        pos = 2'd0;
        dly_target = DLY1;
        case (role)
            CRO_ROLE_POS1: begin
                pos = 2'd0;
                dly_target = DLY1;
            end
            CRO_ROLE_POS2: begin
                pos = 2'd1;
                dly_target = DLY2;
            end
            CRO_ROLE_POS3: begin
                pos = 2'd2;
                dly_target = DLY3;
            end
            default: begin
                standby_role = 1'b0;
            end
        endcase
    end

    // Entry needs on, no redundancy request, standby role
    // Bus high and load under this position's level
    assign entry_ok = on_req && red_sel_n && standby_role && bus_high
                      && !share_above_wake[pos] && !any_fault;

    assign wake_req = !bus_high || share_above_wake[pos] || !wake_n || any_fault;

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= CRO_RUN;
            dly_cnt <= '0;
        end else begin
            case (state)
                CRO_RUN: begin
                    dly_cnt <= '0;
                    if (entry_ok) begin
                        state <= CRO_DELAY;
                    end
                end
                // Delay counted from entry, cancelled by wake
                CRO_DELAY: begin
                    if (!entry_ok || wake_req) begin
                        state <= CRO_RUN;
                    // A role rewrite mid-delay may lower the target below the count
                    end else if (dly_cnt >= dly_target) begin
                        state <= CRO_STANDBY;
                    end else if (tick) begin
                        dly_cnt <= dly_cnt + 1'b1;
                    end
                end
                // A fault or lost condition leaves standby
                CRO_STANDBY: begin
                    if (wake_req || !standby_role || !on_req || !red_sel_n) begin
                        state <= CRO_RUN;
                    end
                end
                default: begin
                    state <= CRO_RUN;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // Wired lines
    // -------------------------------------------------------------
    logic on_req_d;
    logic [CRO_TICK_W-1:0] pulse_cnt;
    logic pulse_evt;

    // Role 00h write and on-request loss are events
    assign pulse_evt = std_written || (on_req_d && !on_req);

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            on_req_d <= 1'b0;
            pulse_cnt <= '0;
        end else begin
            on_req_d <= on_req;
            if (pulse_evt) begin
                pulse_cnt <= WPULSE;
            end else if (tick && pulse_cnt != '0) begin
                pulse_cnt <= pulse_cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            smart_on_bus_oe <= 1'b1;
            shared_wake_fault_n_oe <= 1'b0;
        end else begin
            // Standard role holds the bus low
            smart_on_bus_oe <= (role == CRO_ROLE_STD);
            // Fault or event pulls the wake line
            shared_wake_fault_n_oe <= any_fault || pulse_evt || (pulse_cnt != '0);
        end
    end

    assign smart_on_bus_out = 1'b0;
    assign shared_wake_fault_n_out = 1'b0;

    // -------------------------------------------------------------
    // Outputs and indicator
    // -------------------------------------------------------------
    logic [CRO_TICK_W-1:0] blink_cnt;
    logic blink;
    logic any_warn;

    assign any_warn = |warnings || faults.oc_warn;

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            blink_cnt <= '0;
            blink <= 1'b0;
        end else if (tick) begin
            blink_cnt <= (blink_cnt == BLINK) ? '0 : blink_cnt + 1'b1;
            blink <= (blink_cnt == BLINK) ? !blink : blink;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            main_on <= 1'b0;
            power_good <= 1'b0;
            fans_run <= 1'b0;
            present_n <= 1'b0;
            fault_report <= '0;
        end else begin
            // Both pins low, not in standby
            main_on <= !kill && on_req && (state != CRO_STANDBY) && !any_fault;
            // Standby keeps power good and fans
            power_good <= (state == CRO_STANDBY) || (!kill && on_req && !any_fault);
            fans_run <= (state == CRO_STANDBY) || on_req;
            present_n <= 1'b0;
            fault_report <= (state == CRO_STANDBY) ? '0 : faults;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            led_green <= 1'b0;
            led_amber <= 1'b0;
        end else if (state == CRO_STANDBY) begin
            // Standby blinks green, or amber on warning
            led_green <= !any_warn && blink;
            led_amber <= any_warn && blink;
        end else if (any_fault) begin
            led_green <= 1'b0;
            led_amber <= 1'b1;
        end else if (any_warn) begin
            led_green <= 1'b0;
            led_amber <= blink;
        end else begin
            led_green <= main_on ? 1'b1 : blink;
            led_amber <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    sequence run_to_delay;
        state == CRO_RUN ##1 state == CRO_DELAY;
    endsequence

    kill_off_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        kill |=> !main_on)
        else $error("output on while cutoff high");

    both_low_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        main_on |-> $past(!kill && on_req))
        else $error("output on without both pins low");

    present_low_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        !present_n)
        else $error("presence not low");

    standby_pwok_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        state == CRO_STANDBY |=> power_good && fans_run && !main_on)
        else $error("standby outputs wrong");

    fault_role_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        any_fault |=> role == CRO_ROLE_STD)
        else $error("role not reset by fault");

    write_role_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        wr_ok && !any_fault |=> role == $past(mb_req.data))
        else $error("role write lost");

    std_bus_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        role == CRO_ROLE_STD |=> smart_on_bus_oe)
        else $error("standard role not holding bus");

    bus_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        state == CRO_STANDBY && !bus_high |=> state == CRO_RUN
            ##1 (main_on || $past(kill || !on_req || any_fault)))
        else $error("bus low did not wake");

    fault_line_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        any_fault |=> shared_wake_fault_n_oe)
        else $error("fault line not driven");

    hide_fault_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        state == CRO_STANDBY |=> fault_report == '0)
        else $error("fault reported in standby");

    entry_cond_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        run_to_delay |-> $past(entry_ok))
        else $error("delay begun without entry conditions");

    cancel_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        state == CRO_DELAY && wake_req |=> state == CRO_RUN)
        else $error("wake did not cancel shutdown");

endmodule

// >>> verification/cro_peer_model.sv
`timescale 1ns/1ps
// -----------------------------------------
// Parallel peers on the wired lines
// -----------------------------------------
module cro_peer_model (
    // Design side drive and enables
    input wire logic bus_out,
    input wire logic bus_oe,
    input wire logic wake_out,
    input wire logic wake_oe,
    // Peer drive requests
    input wire logic peer_bus_low,
    input wire logic peer_wake_low,
    // Resolved wire levels
    output logic bus_lvl,
    output logic wake_lvl
);
    // peer pulls bus low; a released line floats to its pull-up
    assign bus_lvl = !peer_bus_low && (!bus_oe || bus_out);
    assign wake_lvl = !peer_wake_low && (!wake_oe || wake_out);
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb import cro_pkg::*; ;
    // -----------------------------------------
    // Signals and instances
    // -----------------------------------------
    // Short tick keeps the 800 ms delay at 3200 cycles
    localparam int TK = 4;
    localparam logic [6:0] ADR = 7'h58;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic on_request_n = 1'b1;
    logic extraction_cutoff = 1'b1;
    logic redundancy_select_n = 1'b0;
    logic peer_bus_low = 1'b0;
    logic peer_wake_low = 1'b0;
    logic [2:0] share_above_wake = 3'h0;
    cro_fault_s faults = '0;
    cro_warn_s warnings = '0;
    logic mb_req_valid = 1'b0;
    cro_mb_req_s mb_req = '0;
    logic smart_on_bus_in, smart_on_bus_oe, shared_wake_fault_n_in, shared_wake_fault_n_oe;
    logic smart_on_bus_out, shared_wake_fault_n_out;
    logic mb_rsp_valid, main_on, power_good, fans_run, led_green, led_amber, present_n;
    cro_mb_rsp_s mb_rsp;
    cro_fault_s fault_report;
    logic [7:0] role;
    int n_errors = 0;
    int total_checks = 0;

    always #10 clk_sys = ~clk_sys;

    cro_peer_model u_peer (.bus_out(smart_on_bus_out), .bus_oe(smart_on_bus_oe),
        .wake_out(shared_wake_fault_n_out), .wake_oe(shared_wake_fault_n_oe),
        .peer_bus_low, .peer_wake_low, .bus_lvl(smart_on_bus_in),
        .wake_lvl(shared_wake_fault_n_in));

    cro_control #(.TICK_CYCLES(TK)) u_dut (.clk_sys, .rst_n, .on_request_n,
        .extraction_cutoff, .redundancy_select_n, .smart_on_bus_in,
        .smart_on_bus_out, .smart_on_bus_oe, .shared_wake_fault_n_in,
        .shared_wake_fault_n_out, .shared_wake_fault_n_oe, .share_above_wake,
        .faults, .warnings, .mb_req_valid, .mb_req, .mb_rsp_valid, .mb_rsp, .main_on,
        .power_good, .fans_run, .led_green, .led_amber, .present_n, .fault_report, .role);

    // -----------------------------------------
    // Shared tasks
    // -----------------------------------------
    task automatic complete_run();
        if (n_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Bitwise packet code, independent of the design's own
    function automatic logic [7:0] crc(input logic [31:0] m, input int nb);
        logic [7:0] c;
        c = 8'h00;
        for (int i = nb * 8 - 1; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction

    task automatic mb(input logic wr, input logic [7:0] cmd, input logic [7:0] d,
                      input logic bad, input logic ack, input logic [7:0] rd);
        mb_req_valid = 1'b1;
        mb_req = '{wr, ADR, cmd, d, crc({8'h00, ADR, 1'b0, cmd, d}, 3) ^ {7'h00, bad}};
        cyc(1);
        mb_req_valid = 1'b0;
        chk(mb_rsp_valid, 1'b1);
        chk(mb_rsp.ack, ack);
        if (!wr) begin
            chk(mb_rsp.data, rd);
            chk(mb_rsp.pec, crc({ADR, 1'b0, cmd, ADR, 1'b1, rd}, 4));
        end
        cyc(1);
    endtask

    task automatic wait_on(input logic exp, input int lim, output int n);
        n = 0;
        while (main_on !== exp && n < lim) begin
            cyc(1);
            n++;
        end
        if (main_on !== exp) begin
            n_errors++;
            complete_run();
        end
    endtask

    task automatic blink(output int g, output int a);
        logic pg;
        logic pa;
        g = 0;
        a = 0;
        pg = led_green;
        pa = led_amber;
        repeat (1100 * TK) begin
            cyc(1);
            g += int'(led_green !== pg);
            a += int'(led_amber !== pa);
            pg = led_green;
            pa = led_amber;
        end
    endtask

    // -----------------------------------------
    // Scenarios
    // -----------------------------------------
    task automatic s_reset();
        chk(role, 8'h00);
        chk(present_n, 1'b0);
        chk(smart_on_bus_oe, 1'b1);
        chk(smart_on_bus_in, 1'b0);
        mb(1'b0, 8'hd0, 8'h00, 1'b0, 1'b1, 8'h00);
    endtask

    task automatic s_pins();
        for (int i = 3; i >= 0; i--) begin
            {extraction_cutoff, on_request_n} = 2'(i);
            cyc(5);
            chk(main_on, i == 0);
        end
    endtask

    task automatic s_cfg();
        mb(1'b1, 8'hd1, 8'h03, 1'b0, 1'b0, 8'h00);
        mb(1'b1, 8'hd0, 8'h03, 1'b1, 1'b0, 8'h00);
        mb(1'b0, 8'hd0, 8'h00, 1'b0, 1'b1, 8'h00);
        mb(1'b1, 8'hd0, 8'h03, 1'b0, 1'b1, 8'h00);
        mb(1'b0, 8'hd0, 8'h00, 1'b0, 1'b1, 8'h03);
    endtask

    task automatic s_hold();
        for (int r = 0; r < 2; r++) begin
            mb(1'b1, 8'hd0, 8'(r), 1'b0, 1'b1, 8'h00);
            redundancy_select_n = 1'b1;
            cyc(1000 * TK);
            chk(main_on, 1'b1);
        end
        redundancy_select_n = 1'b0;
    endtask

    task automatic s_delay(input logic [7:0] r, input int d, input int w);
        int n;
        mb(1'b1, 8'hd0, r, 1'b0, 1'b1, 8'h00);
        cyc(d * TK + 20);
        chk(main_on, 1'b1);
        redundancy_select_n = 1'b1;
        wait_on(1'b0, (d + 2) * TK + 20, n);
        chk(n >= (d - 1) * TK && n <= (d + 1) * TK + 8, 1'b1);
        chk(power_good && fans_run, 1'b1);
        chk(fault_report, 8'h00);
        case (w)
            0: peer_bus_low = 1'b1;
            1: share_above_wake = 3'h1 << (r - 8'h02);
            default: peer_wake_low = 1'b1;
        endcase
        wait_on(1'b1, 10, n);
        redundancy_select_n = 1'b0;
        cyc(4);
        {peer_bus_low, peer_wake_low, share_above_wake} = '0;
    endtask

    task automatic s_cancel();
        int n;
        int g;
        int a;
        mb(1'b1, 8'hd0, 8'h02, 1'b0, 1'b1, 8'h00);
        redundancy_select_n = 1'b1;
        cyc(400 * TK);
        peer_bus_low = 1'b1;
        cyc(4);
        peer_bus_low = 1'b0;
        cyc(500 * TK);
        chk(main_on, 1'b1);
        wait_on(1'b0, 400 * TK, n);
        blink(g, a);
        chk(g > 1 && a == 0, 1'b1);
        warnings.temp_warn = 1'b1;
        blink(g, a);
        chk(a > 1, 1'b1);
        warnings = '0;
        faults.ot_fault = 1'b1;
        cyc(1);
        chk(fault_report, 8'h00);
        cyc(5);
        chk(role, 8'h00);
        chk(fault_report, 8'h04);
        chk(shared_wake_fault_n_oe, 1'b1);
        faults = '0;
        redundancy_select_n = 1'b0;
        cyc(12 * TK);
    endtask

    task automatic s_faults();
        for (int i = 0; i < 7; i++) begin
            mb(1'b1, 8'hd0, 8'h02, 1'b0, 1'b1, 8'h00);
            faults = 7'h01 << i;
            cyc(5);
            chk(role, 8'h00);
            chk(shared_wake_fault_n_oe, 1'b1);
            chk(fault_report, 8'h01 << i);
            mb(1'b1, 8'hd0, 8'h03, 1'b0, 1'b1, 8'h00);
            chk(role, 8'h00);
            faults = '0;
            cyc(12 * TK);
            chk(shared_wake_fault_n_oe, 1'b0);
        end
    endtask

    task automatic s_wake_src();
        mb(1'b1, 8'hd0, 8'h02, 1'b0, 1'b1, 8'h00);
        mb(1'b1, 8'hd0, 8'h00, 1'b0, 1'b1, 8'h00);
        chk(shared_wake_fault_n_oe, 1'b1);
        chk(shared_wake_fault_n_in, 1'b0);
        cyc(12 * TK);
        chk(shared_wake_fault_n_oe, 1'b0);
        on_request_n = 1'b1;
        cyc(5);
        chk(shared_wake_fault_n_oe, 1'b1);
        chk(main_on, 1'b0);
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        cyc(4);
        s_reset();
        s_pins();
        s_cfg();
        s_hold();
        s_delay(8'h02, 800, 0);
        s_delay(8'h03, 600, 1);
        s_delay(8'h04, 400, 2);
        s_cancel();
        s_faults();
        s_wake_src();
        complete_run();
    end
endmodule
